// *** inc/lbu_consts.vh ***
/*
 * Constants of the logic and bit-field unit: register offsets, field
 * positions, operation classes and reset values.
 * Assumes it is included by its bare name from the design files.
 */
// Functional notes
// - Logical code 1111 gives all zeros, code 0000 all ones.
// - Codes 1110..1000: and, and-not, pass A, not-and, pass B, xor, or.
// - Codes 0111..0001: nor, xnor, not B, or-not, not A, not-or, nand.
// - Byte test 0: result nonzero; byte test 1: every byte nonzero.
// - Static forms use instruction offset/width; dynamic use state word offset, and its width for odd codes only.
// - Extract shifts B right arithmetically, keeps low width bits, into A.
// - Extract field beyond bit 31 holds the sign bit.
// - Deposit places low width bits of B at offset, other bits zero.
// - Merge overlays the field on A, keeping A outside the field.
// - Deposit and merge truncate the field so it ends at bit 31.
// - Merge immediate inserts sign-extended 5-bit constant into A.
// - Dynamic codes 0..5 select deposit, merge, extract, fixed or reg width.
// - Merge halfword high puts the 16-bit constant in A bits 31..16.
// - Field operations set the outcome when the result is nonzero.
`ifndef LBU_CONSTS_VH
`define LBU_CONSTS_VH

`define LBU_ADDR_W 8
`define LBU_OFF_SRC_A 8'h00
`define LBU_OFF_SRC_B 8'h04
`define LBU_OFF_MASK 8'h08
`define LBU_OFF_PSW 8'h0c
`define LBU_OFF_INSTR 8'h10
`define LBU_OFF_HALF 8'h14
`define LBU_OFF_ISSUE 8'h18
`define LBU_OFF_DEST 8'h1c
`define LBU_OFF_STATUS 8'h20

`define LBU_PSW_SAR_LSB 0
`define LBU_PSW_FLR_LSB 8

`define LBU_INS_CLASS_LSB 0
`define LBU_INS_FUNC_LSB 4
`define LBU_INS_BYTE_TEST 8
`define LBU_INS_KEEP 9
`define LBU_INS_OFFSET_LSB 10
`define LBU_INS_WIDTH_LSB 15
`define LBU_INS_IMM_LSB 20

`define LBU_ST_OUTCOME 0
`define LBU_ST_BAD_OP 1

`define LBU_CL_LOGIC 4'h0
`define LBU_CL_DEPOSIT 4'h1
`define LBU_CL_EXTRACT 4'h2
`define LBU_CL_MERGE_IMM 4'h3
`define LBU_CL_DYNAMIC 4'h4
`define LBU_CL_MERGE_HIGH 4'h5
`define LBU_CL_BIT_MERGE 4'h6

`define LBU_DYN_LAST 4'h5
`define LBU_FN_ZEROS 4'hf
`define LBU_FN_ONES 4'h0

`define LBU_RESP_OKAY 2'b00
`define LBU_RESP_SLVERR 2'b10
`define LBU_RESET_WORD 32'h0000_0000

`endif

// *** design/lbu_field.v ***
/*
 * Combinational field engine: extract, deposit and merge of a bit field.
 * Assumes offset, width code and operands are stable for the cycle.
 */
`timescale 1ns/1ps
`include "lbu_consts.vh"

module lbu_field (
	input wire [31:0] old_value,
	input wire [31:0] src_value,
	input wire [4:0] offset,
	input wire [4:0] width_code,
	input wire keep,
	input wire extract,
	output reg [31:0] result
);

	reg [5:0] len;
	reg [6:0] fend;
	reg [5:0] dep_len;
	reg [32:0] low_mask;
	reg [32:0] dep_low;
	reg [31:0] dep_mask;
	reg [31:0] shifted;

	always @* begin
		len = (width_code == 5'h00) ? 6'd32 : {1'b0, width_code};
		fend = {1'b0, len} + {2'b00, offset};
		dep_len = len;
		if (fend > 7'd32) begin
			dep_len = 6'd32 - {1'b0, offset};
		end
		low_mask = (33'h1 << len) - 33'h1;
		dep_low = (33'h1 << dep_len) - 33'h1;
		dep_mask = dep_low[31:0] << offset;
		if (extract) begin
			// Arithmetic shift supplies sign copies past bit 31.
			shifted = $signed(src_value) >>> offset;
			result = shifted & low_mask[31:0];
		end else begin
			shifted = src_value << offset;
			if (keep) begin
				result = (old_value & ~dep_mask) | (shifted & dep_mask);
			end else begin
				result = shifted & dep_mask;
			end
		end
	end

endmodule // lbu_field

// *** design/lbu_top.v ***
/*
 * Logic and bit-field unit with its AXI4-Lite register slave.
 * Assumes an AXI4-Lite master on aclk; one write and one read at a time.
 */
`timescale 1ns/1ps
`include "lbu_consts.vh"

module lbu_top (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [31:0] dest_value,
	output reg test_outcome
);

	reg aw_held;
	reg w_held;
	reg [7:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg next_aw_held;
	reg next_w_held;
	reg next_rvalid;
	wire do_write;
	wire [31:0] strb_mask;

	reg [31:0] source_a_reg;
	reg [31:0] source_b_reg;
	reg [31:0] bit_mask_reg;
	reg [4:0] shift_amount_reg;
	reg [4:0] field_size_reg;
	reg [24:0] instr_word;
	reg [15:0] half_constant;
	reg bad_op;

	wire [3:0] op_class;
	wire [3:0] func_code;
	wire byte_test_flag;
	wire keep_old_bits;
	wire [4:0] bit_offset;
	wire [4:0] field_width;
	wire [4:0] short_constant;

	reg [31:0] logic_result;
	reg [31:0] next_result;
	reg next_outcome;
	reg next_to_a;
	reg next_bad;
	reg [4:0] fu_offset;
	reg [4:0] fu_width;
	reg [31:0] fu_src;
	reg fu_keep;
	reg fu_extract;
	wire [31:0] fu_result;
	wire [31:0] psw_word;
	wire [31:0] status_word;
	wire issue;
	wire [31:0] write_value_a;
	wire [31:0] write_value_b;
	wire [31:0] write_value_m;
	wire [31:0] write_value_p;
	wire [31:0] write_value_i;
	wire [31:0] write_value_h;
	wire addr_ok_w;

	genvar gi;

	// Byte enables become a bit mask for the partial register writes.
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_strb
			assign strb_mask[8*gi+7:8*gi] = {8{w_strb_q[gi]}};
		end
	endgenerate

	assign op_class = instr_word[`LBU_INS_CLASS_LSB+3:`LBU_INS_CLASS_LSB];
	assign func_code = instr_word[`LBU_INS_FUNC_LSB+3:`LBU_INS_FUNC_LSB];
	assign byte_test_flag = instr_word[`LBU_INS_BYTE_TEST];
	assign keep_old_bits = instr_word[`LBU_INS_KEEP];
	assign bit_offset = instr_word[`LBU_INS_OFFSET_LSB+4:`LBU_INS_OFFSET_LSB];
	assign field_width = instr_word[`LBU_INS_WIDTH_LSB+4:`LBU_INS_WIDTH_LSB];
	assign short_constant = instr_word[`LBU_INS_IMM_LSB+4:`LBU_INS_IMM_LSB];

	assign psw_word = {19'h0_0000, field_size_reg, 3'h0, shift_amount_reg};
	assign status_word = {30'h0000_0000, bad_op, test_outcome};

	// Write address and data may arrive in either order.
	assign do_write = aw_held & w_held & ~s_axi_bvalid;
	assign issue = do_write & (aw_addr_q == `LBU_OFF_ISSUE);

	assign write_value_a = (source_a_reg & ~strb_mask) | (w_data_q & strb_mask);
	assign write_value_b = (source_b_reg & ~strb_mask) | (w_data_q & strb_mask);
	assign write_value_m = (bit_mask_reg & ~strb_mask) | (w_data_q & strb_mask);
	assign write_value_p = (psw_word & ~strb_mask) | (w_data_q & strb_mask);
	assign write_value_i = ({7'h00, instr_word} & ~strb_mask) |
		(w_data_q & strb_mask);
	assign write_value_h = ({16'h0000, half_constant} & ~strb_mask) |
		(w_data_q & strb_mask);

	assign addr_ok_w = (aw_addr_q == `LBU_OFF_SRC_A) ||
		(aw_addr_q == `LBU_OFF_SRC_B) || (aw_addr_q == `LBU_OFF_MASK) ||
		(aw_addr_q == `LBU_OFF_PSW) || (aw_addr_q == `LBU_OFF_INSTR) ||
		(aw_addr_q == `LBU_OFF_HALF) || (aw_addr_q == `LBU_OFF_ISSUE);

	// The sixteen two-operand logical functions.
	always @* begin
		case (func_code)
			`LBU_FN_ZEROS: logic_result = 32'h0000_0000;
			4'he: logic_result = source_a_reg & source_b_reg;
			4'hd: logic_result = source_a_reg & ~source_b_reg;
			4'hc: logic_result = source_a_reg;
			4'hb: logic_result = ~source_a_reg & source_b_reg;
			4'ha: logic_result = source_b_reg;
			4'h9: logic_result = source_a_reg ^ source_b_reg;
			4'h8: logic_result = source_a_reg | source_b_reg;
			4'h7: logic_result = ~(source_a_reg | source_b_reg);
			4'h6: logic_result = ~(source_a_reg ^ source_b_reg);
			4'h5: logic_result = ~source_b_reg;
			4'h4: logic_result = source_a_reg | ~source_b_reg;
			4'h3: logic_result = ~source_a_reg;
			4'h2: logic_result = ~source_a_reg | source_b_reg;
			4'h1: logic_result = ~(source_a_reg & source_b_reg);
			`LBU_FN_ONES: logic_result = 32'hffff_ffff;
			default: logic_result = 32'h0000_0000;
		endcase
	end

	// Steering of the field engine for static, immediate and dynamic forms.
	always @* begin
		fu_offset = bit_offset;
		fu_width = field_width;
		fu_src = source_b_reg;
		fu_keep = keep_old_bits;
		fu_extract = 1'b0;
		case (op_class)
			`LBU_CL_EXTRACT: begin
				fu_extract = 1'b1;
			end
			`LBU_CL_MERGE_IMM: begin
				fu_src = {{27{short_constant[4]}}, short_constant};
				fu_keep = 1'b1;
			end
			`LBU_CL_DYNAMIC: begin
				fu_offset = shift_amount_reg;
				if (func_code[0]) begin
					fu_width = field_size_reg;
				end
				fu_keep = func_code[1];
				fu_extract = func_code[2];
			end
			default: begin
				fu_extract = 1'b0;
			end
		endcase
	end

	lbu_field u_field (
		.old_value(source_a_reg),
		.src_value(fu_src),
		.offset(fu_offset),
		.width_code(fu_width),
		.keep(fu_keep),
		.extract(fu_extract),
		.result(fu_result)
	);

	// Result, condition and destination of the issued operation.
	always @* begin
		next_result = fu_result;
		next_to_a = 1'b1;
		next_bad = 1'b0;
		case (op_class)
			`LBU_CL_LOGIC: begin
				next_result = logic_result;
				next_to_a = 1'b0;
			end
			`LBU_CL_DEPOSIT, `LBU_CL_EXTRACT, `LBU_CL_MERGE_IMM: begin
				next_result = fu_result;
			end
			`LBU_CL_DYNAMIC: begin
				next_result = fu_result;
				next_bad = (func_code > `LBU_DYN_LAST);
			end
			`LBU_CL_MERGE_HIGH: begin
				next_result = {half_constant, source_a_reg[15:0]};
			end
			`LBU_CL_BIT_MERGE: begin
				next_result = (source_a_reg & ~bit_mask_reg) |
					(source_b_reg & bit_mask_reg);
				next_to_a = 1'b0;
			end
			default: begin
				next_bad = 1'b1;
			end
		endcase
		if ((op_class == `LBU_CL_LOGIC) && byte_test_flag) begin
			next_outcome = (next_result[31:24] != 8'h00) &&
				(next_result[23:16] != 8'h00) &&
				(next_result[15:8] != 8'h00) &&
				(next_result[7:0] != 8'h00);
		end else begin
			next_outcome = (next_result != 32'h0000_0000);
		end
	end

	// Write address and data acceptance, plus the read valid next state.
	always @* begin
		if (aw_held) begin
			next_aw_held = ~do_write;
		end else begin
			next_aw_held = s_axi_awvalid & s_axi_awready;
		end
		if (w_held) begin
			next_w_held = ~do_write;
		end else begin
			next_w_held = s_axi_wvalid & s_axi_wready;
		end
		if (s_axi_rvalid) begin
			next_rvalid = ~s_axi_rready;
		end else begin
			next_rvalid = s_axi_arvalid & s_axi_arready;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= `LBU_RESET_WORD;
			w_strb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LBU_RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			s_axi_awready <= ~next_aw_held;
			s_axi_wready <= ~next_w_held;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_ok_w ? `LBU_RESP_OKAY : `LBU_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register file and execution; an issue completes at its own edge.
	always @(posedge aclk) begin
		if (!aresetn) begin
			source_a_reg <= `LBU_RESET_WORD;
			source_b_reg <= `LBU_RESET_WORD;
			bit_mask_reg <= `LBU_RESET_WORD;
			shift_amount_reg <= 5'h00;
			field_size_reg <= 5'h00;
			instr_word <= 25'h000_0000;
			half_constant <= 16'h0000;
			dest_value <= `LBU_RESET_WORD;
			test_outcome <= 1'b0;
			bad_op <= 1'b0;
		end else if (issue) begin
			bad_op <= next_bad;
			if (!next_bad) begin
				test_outcome <= next_outcome;
				if (next_to_a) begin
					source_a_reg <= next_result;
				end else begin
					dest_value <= next_result;
				end
			end
		end else if (do_write) begin
			case (aw_addr_q)
				`LBU_OFF_SRC_A: source_a_reg <= write_value_a;
				`LBU_OFF_SRC_B: source_b_reg <= write_value_b;
				`LBU_OFF_MASK: bit_mask_reg <= write_value_m;
				`LBU_OFF_PSW: begin
					shift_amount_reg <= write_value_p[`LBU_PSW_SAR_LSB+4:
						`LBU_PSW_SAR_LSB];
					field_size_reg <= write_value_p[`LBU_PSW_FLR_LSB+4:
						`LBU_PSW_FLR_LSB];
				end
				`LBU_OFF_INSTR: instr_word <= write_value_i[24:0];
				`LBU_OFF_HALF: half_constant <= write_value_h[15:0];
				default: bad_op <= bad_op;
			endcase
		end
	end

	// Read channel; data is registered one cycle after the address.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `LBU_RESET_WORD;
			s_axi_rresp <= `LBU_RESP_OKAY;
		end else begin
			s_axi_rvalid <= next_rvalid;
			s_axi_arready <= ~next_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rresp <= `LBU_RESP_OKAY;
				case ({s_axi_araddr[7:2], 2'b00})
					`LBU_OFF_SRC_A: s_axi_rdata <= source_a_reg;
					`LBU_OFF_SRC_B: s_axi_rdata <= source_b_reg;
					`LBU_OFF_MASK: s_axi_rdata <= bit_mask_reg;
					`LBU_OFF_PSW: s_axi_rdata <= psw_word;
					`LBU_OFF_INSTR: s_axi_rdata <= {7'h00, instr_word};
					`LBU_OFF_HALF: s_axi_rdata <= {16'h0000, half_constant};
					`LBU_OFF_ISSUE: s_axi_rdata <= `LBU_RESET_WORD;
					`LBU_OFF_DEST: s_axi_rdata <= dest_value;
					`LBU_OFF_STATUS: s_axi_rdata <= status_word;
					default: begin
						s_axi_rdata <= `LBU_RESET_WORD;
						s_axi_rresp <= `LBU_RESP_SLVERR;
					end
				endcase
			end
		end
	end

endmodule // lbu_top

// *** testbench/lbu_checker.sv ***
/* Assertions on the bus answers and result outputs of lbu_top.
   Assumes it is bound to lbu_top and sees only its ports. */
`timescale 1ns/1ps
module lbu_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] dest_value,
	input wire logic test_outcome
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_dest_issue: assert property (
		$changed(dest_value) |-> $rose(s_axi_bvalid))
		else $error("dest_value moved without an issue");
	a_outcome_issue: assert property (
		$changed(test_outcome) |-> $rose(s_axi_bvalid))
		else $error("test_outcome moved without an issue");
	a_zero_outcome: assert property (
		$changed(dest_value) && dest_value == 0 |-> !test_outcome)
		else $error("zero result raised test_outcome");
	a_bytes_outcome: assert property (
		$changed(dest_value) && dest_value[31:24] != 0 &&
		dest_value[23:16] != 0 && dest_value[15:8] != 0 &&
		dest_value[7:0] != 0 |-> test_outcome)
		else $error("full bytes left test_outcome low");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
		$stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer dropped early");
	a_write_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
		$stable(s_axi_bresp))
		else $error("write answer dropped early");
	a_ar_busy: assert property (
		s_axi_rvalid |-> !s_axi_arready && s_axi_rresp[0] == 1'b0)
		else $error("address taken while answer pending");
endmodule // lbu_checker

bind lbu_top lbu_checker lbu_checker_inst (.*);

// *** testbench/lbu_seq_model.sv ***
/* Issuing side: a register bus master that moves one word at a time.
   Assumes an answering slave on aclk; slow delays the answer ready. */
`timescale 1ns/1ps
module lbu_seq_model (
	input wire logic aclk,
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	logic slow = 1'b0;
	logic [3:0] strb = 4'hf;
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = 0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
		s_axi_wstrb = 4'hf;
	end
	// One transfer at a time, so no write overlaps the answer of the one before.
	task wr(input [7:0] a, input [31:0] v, output [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= strb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= !slow;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~v;
			end
			if (n == 3 && !s_axi_bready)
				s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready));
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task rd(input [7:0] a, output [31:0] v, output [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !slow;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
			if (n == 3 && !s_axi_rready)
				s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready));
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule // lbu_seq_model

// *** testbench/tb_lbu_top.sv ***
/* Self-checking bench for lbu_top, driven through lbu_seq_model.
   Assumes the register map and operation classes of lbu_consts.vh. */
`timescale 1ns/1ps
module tb_lbu_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	wire [7:0] s_axi_awaddr, s_axi_araddr;
	wire [31:0] s_axi_wdata, s_axi_rdata, dest_value;
	wire [3:0] s_axi_wstrb;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	wire s_axi_rvalid, s_axi_rready, test_outcome;
	int errors = 0;
	int samples_checked = 0;
	logic [31:0] d;
	logic [1:0] rs;
	lbu_top lbu_top_inst (.*);
	lbu_seq_model lbu_seq_model_inst (.*);
	always #4 aclk = ~aclk;
	task chk(input [31:0] g, input [31:0] e);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task w(input [7:0] a, input [31:0] v, input [1:0] er);
		lbu_seq_model_inst.wr(a, v, rs);
		chk({30'h0, rs}, {30'h0, er});
	endtask
	task r(input [7:0] a, input [31:0] e, input [1:0] er);
		lbu_seq_model_inst.rd(a, d, rs);
		chk(d, e);
		chk({30'h0, rs}, {30'h0, er});
	endtask
	function [31:0] ins(input [3:0] cl, fn, input bt, kp,
		input [4:0] of, wd, im);
		ins = {7'h0, im, wd, of, kp, bt, fn, cl};
	endfunction
	function [31:0] lg(input [3:0] c, input [31:0] a, b);
		case (c)
			4'hf: lg = 32'h0;
			4'he: lg = a & b;
			4'hd: lg = a & ~b;
			4'hc: lg = a;
			4'hb: lg = ~a & b;
			4'ha: lg = b;
			4'h9: lg = a ^ b;
			4'h8: lg = a | b;
			4'h7: lg = ~(a | b);
			4'h6: lg = ~(a ^ b);
			4'h5: lg = ~b;
			4'h4: lg = a | ~b;
			4'h3: lg = ~a;
			4'h2: lg = ~a | b;
			4'h1: lg = ~(a & b);
			default: lg = 32'hffff_ffff;
		endcase
	endfunction
	// Loads sources, issues one operation and reads the result back.
	task op(input [31:0] a, b, m, p, i, input [15:0] h,
		input [7:0] ra, input [31:0] e, input eo);
		w(8'h00, a, 2'b00);
		w(8'h04, b, 2'b00);
		w(8'h08, m, 2'b00);
		w(8'h0c, p, 2'b00);
		w(8'h10, i, 2'b00);
		w(8'h14, {16'h0, h}, 2'b00);
		w(8'h18, 32'h0, 2'b00);
		r(ra, e, 2'b00);
		if (ra == 8'h1c) chk(dest_value, e);
		chk({31'h0, test_outcome}, {31'h0, eo});
	endtask
	task t_logic;
		logic [31:0] e;
		for (int bt = 0; bt < 2; bt++)
			for (int c = 0; c < 16; c++) begin
				e = lg(c[3:0], 32'hff00_f0f0, 32'hf0f0_ff00);
				op(32'hff00_f0f0, 32'hf0f0_ff00, 0, 0,
					ins(0, c[3:0], bt[0], 0, 0, 0, 0), 0, 8'h1c, e,
					bt ? &{|e[31:24], |e[23:16], |e[15:8], |e[7:0]} : |e);
			end
		$display("test logic done");
	endtask
	task t_field;
		op(0, 32'h8000_00f0, 0, 0, ins(2, 0, 0, 0, 4, 8, 0), 0, 0, 32'hf, 1);
		op(0, 32'h8000_00f0, 0, 0, ins(2, 0, 0, 0, 28, 8, 0), 0, 0, 32'hf8, 1);
		op(0, 32'h8000_00f0, 0, 0, ins(2, 0, 0, 0, 4, 0, 0), 0, 0,
			32'hf800_000f, 1);
		op(0, 32'hf00, 0, 0, ins(2, 0, 0, 0, 0, 8, 0), 0, 0, 0, 0);
		op(~0, 32'hab, 0, 0, ins(1, 0, 0, 0, 8, 4, 0), 0, 0, 32'hb00, 1);
		op(~0, 32'hab, 0, 0, ins(1, 0, 0, 1, 8, 4, 0), 0, 0,
			32'hffff_fbff, 1);
		op(~0, 32'h1234_5678, 0, 0, ins(1, 0, 0, 1, 8, 0, 0), 0, 0,
			32'h3456_78ff, 1);
		op(~0, 32'hab, 0, 0, ins(3, 0, 0, 0, 4, 8, 5'h10), 0, 0,
			32'hffff_ff0f, 1);
		op(32'h1234_5678, 0, 0, 0, ins(5, 0, 0, 0, 0, 0, 0), 16'habcd, 0,
			32'habcd_5678, 1);
		$display("test field done");
	endtask
	task t_dyn;
		static logic [31:0] ex [6] = '{32'h50, 32'ha50, 32'hffff_ff5f,
			32'hffff_fa5f, 32'ha, 32'hca};
		for (int f = 0; f < 6; f++)
			op(~0, 32'h8000_0ca5, 0, 32'h804, ins(4, f[3:0], 0, 0, 12, 4, 0),
				0, 0, ex[f], 1);
		$display("test dynamic done");
	endtask
	task t_misc;
		op(32'hffff_0000, 32'h1234_5678, 32'h0f0f_0f0f, 0,
			ins(6, 0, 0, 0, 0, 0, 0), 0, 8'h1c, 32'hf2f4_0608, 1);
		// Middle byte lanes only: the outer bytes must keep their old value.
		w(8'h00, 32'hffff_ffff, 2'b00);
		lbu_seq_model_inst.strb = 4'h6;
		w(8'h00, 32'h0, 2'b00);
		lbu_seq_model_inst.strb = 4'hf;
		r(8'h00, 32'hff00_00ff, 2'b00);
		lbu_seq_model_inst.slow = 1'b1;
		w(8'h10, ins(7, 0, 0, 0, 0, 0, 0), 2'b00);
		w(8'h18, 32'h0, 2'b00);
		r(8'h20, 32'h3, 2'b00);
		r(8'h18, 32'h0, 2'b00);
		r(8'h40, 32'h0, 2'b10);
		w(8'h40, 32'h1, 2'b10);
		lbu_seq_model_inst.slow = 1'b0;
		$display("test misc done");
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		complete_run;
	end
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		r(8'h1c, 32'h0, 2'b00);
		r(8'h20, 32'h0, 2'b00);
		t_logic;
		t_field;
		t_dyn;
		t_misc;
		complete_run;
	end
endmodule // tb_lbu_top
